// ### rtl/cfg_bank_pkg.sv
// Constants and shared types of the paged configuration bank
package cfg_bank_pkg;
	localparam int WORD_BITS = 24;
	localparam int ADDR_BITS = 16;
	localparam int DATA_BITS = 8;
	localparam logic [4:0] LAST_ADDR_BIT = 5'h0F;
	localparam logic [4:0] LAST_WORD_BIT = 5'h17;
	localparam logic [4:0] FIRST_DATA_BIT = 5'h10;
	localparam logic [14:0] OFS_PAGE_MAIN = 15'h0012;
	localparam logic [14:0] OFS_PAGE_ANALOG = 15'h0013;
	localparam logic [14:0] OFS_TRIM_RATE = 15'h0064;
	localparam logic [14:0] OFS_REF_MASK = 15'h006A;
	localparam logic [14:0] OFS_SWING = 15'h006F;
	localparam logic [14:0] OFS_DEEMPH = 15'h0071;
	localparam logic [14:0] OFS_CW1_LO = 15'h008D;
	localparam logic [14:0] OFS_CW1_HI = 15'h008E;
	localparam logic [14:0] OFS_CW2_LO = 15'h008F;
	localparam logic [14:0] OFS_CW2_HI = 15'h0090;
	localparam logic [14:0] OFS_TEST_CTRL = 15'h0091;
	localparam logic [14:0] OFS_SPECIAL0 = 15'h00AB;
	localparam logic [14:0] OFS_SPECIAL1 = 15'h00AC;
	localparam logic [14:0] OFS_DDC_AB = 15'h00AD;
	localparam logic [14:0] OFS_DDC_CD = 15'h00AE;
	localparam logic [14:0] OFS_TRIM_GO = 15'h00B7;
	localparam int BIT_SEL_LINK_CD = 6;
	localparam int BIT_SEL_LINK_AB = 5;
	localparam int BIT_SEL_CHAN_A = 1;
	localparam int BIT_SEL_TOP = 0;
	localparam int BIT_SEL_ANALOG = 0;
	localparam int BIT_TRIM_RATE = 1;
	localparam int BIT_REF_MASK = 1;
	localparam int BIT_SPECIAL = 0;
	localparam int BIT_TRIM_GO = 0;
	localparam int LSB_CHOICE = 4;
	localparam int LSB_SWING = 4;
	localparam int LSB_DEEMPH_B = 6;
	localparam logic [3:0] PAT_DEFAULT = 4'h0;
	localparam logic [3:0] PAT_ZEROS = 4'h1;
	localparam logic [3:0] PAT_ONES = 4'h2;
	localparam logic [3:0] PAT_TOGGLE = 4'h3;
	localparam logic [3:0] PAT_RAMP = 4'h4;
	localparam logic [3:0] PAT_CUSTOM1 = 4'h6;
	localparam logic [3:0] PAT_ALT = 4'h7;
	localparam logic [3:0] PAT_DESKEW = 4'h8;
	localparam logic [15:0] DESKEW_WORD = 16'hAAAA;
	localparam logic [15:0] ALL_ONES = 16'hFFFF;
	localparam logic [15:0] RAMP_STEP = 16'h0001;
	localparam logic [7:0] RST_BYTE = 8'h00;
	typedef struct packed {
		logic [2:0] sen_s;
		logic [2:0] clk_s;
		logic [2:0] din_s;
		logic sen_l;
		logic clk_l;
		logic din_l;
		logic [22:0] shreg;
		logic [4:0] cnt;
		logic rd;
		logic load;
		logic [7:0] rsh;
		logic dout;
		logic oe_n;
		logic wr;
		logic [14:0] addr;
		logic [7:0] wdata;
	} port_st_t;
	localparam port_st_t PORT_RST = '{sen_s: 3'h7, sen_l: 1'b1, oe_n: 1'b1, default: '0};
endpackage

// ### rtl/reg_access_if.sv
// Register access strobe, address and data between serial port and bank
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
	logic wr_stb;
	logic [14:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport port(output wr_stb, output addr, output wdata, input rdata);
	modport bank(input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### rtl/serial_reg_port.sv
// Serial 24-bit register access port, oversampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module serial_reg_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sen_n_pin,
	input wire logic sclk_pin,
	input wire logic sdin_pin,
	output logic sdout,
	output logic sdout_oe_n,
	reg_access_if.port acc
);
	cfg_bank_pkg::port_st_t q;
	cfg_bank_pkg::port_st_t next_q;
	logic sen_chg;
	logic clk_chg;
	logic din_chg;
	logic rise;
	logic fall;

	// A pin level counts once the second and third stages agree
	assign sen_chg = (q.sen_s[1] == q.sen_s[2]) && (q.sen_s[2] != q.sen_l);
	assign clk_chg = (q.clk_s[1] == q.clk_s[2]) && (q.clk_s[2] != q.clk_l);
	assign din_chg = (q.din_s[1] == q.din_s[2]) && (q.din_s[2] != q.din_l);
	assign rise = clk_chg && q.clk_s[2] && !q.sen_l;
	assign fall = clk_chg && !q.clk_s[2] && !q.sen_l;

	always_comb begin
		next_q = q;
		next_q.sen_s = {q.sen_s[1:0], sen_n_pin};
		next_q.clk_s = {q.clk_s[1:0], sclk_pin};
		next_q.din_s = {q.din_s[1:0], sdin_pin};
		next_q.wr = 1'b0;
		next_q.load = 1'b0;
		if (sen_chg) begin
			next_q.sen_l = q.sen_s[2];
		end
		if (clk_chg) begin
			next_q.clk_l = q.clk_s[2];
		end
		if (din_chg) begin
			next_q.din_l = q.din_s[2];
		end
		if (q.sen_l) begin
			next_q.cnt = 5'h00;
			next_q.oe_n = 1'b1;
		end else if (rise) begin
			next_q.shreg = {q.shreg[21:0], q.din_l};
			next_q.cnt = q.cnt + 5'h01;
			if (q.cnt == cfg_bank_pkg::LAST_ADDR_BIT) begin
				next_q.addr = {q.shreg[13:0], q.din_l};
				next_q.rd = q.shreg[14];
				next_q.load = 1'b1;
			end
			if (q.cnt == cfg_bank_pkg::LAST_WORD_BIT) begin
				// Words repeat back to back while enable stays low
				next_q.cnt = 5'h00;
				next_q.wdata = {q.shreg[6:0], q.din_l};
				next_q.wr = !q.rd;
			end
		end else if (fall) begin
			if (q.rd && q.cnt >= cfg_bank_pkg::FIRST_DATA_BIT) begin
				next_q.dout = q.rsh[7];
				next_q.rsh = {q.rsh[6:0], 1'b0};
				next_q.oe_n = 1'b0;
			end else begin
				next_q.oe_n = 1'b1;
			end
		end
		if (q.load) begin
			next_q.rsh = acc.rdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= cfg_bank_pkg::PORT_RST;
		end else begin
			q <= next_q;
		end
	end

	assign acc.wr_stb = q.wr;
	assign acc.addr = q.addr;
	assign acc.wdata = q.wdata;
	assign sdout = q.dout;
	assign sdout_oe_n = q.oe_n;

	word_end_a: assert property (@(posedge clk) disable iff (!rst_n) q.wr |-> $past(q.cnt) == 5'h17 && q.cnt == 5'h00)
		else $error("write strobe not at end of 24-bit word");
endmodule
`default_nettype wire

// ### rtl/paged_config_register_bank.sv
// Paged configuration register bank with test pattern source
// Overview of operation
// - Page select bit 6 enables link page CD, bit 5 link page AB.
// - Page select bits 4..1 enable channel pages D, C, B, A.
// - Page select bit 0 enables the top digital page.
// - Bit 0 at 13h enables the analog page.
// - Bit 1 at 64h picks trim load rate: 0 is 375, 1 is 500 MSPS.
// - First custom word sits at 8Dh/8Eh, sent in single or dual custom choice.
// - Second custom word sits at 8Fh/90h, used only in alternating choice.
// - Bits 7-4 at 91h choose the test output pattern.
// - Bits 3..0 at 91h put the pattern on channels D, C, B, A.
// - Bits 3-0 at Downconv_mode_pair_ab give the pair AB down-conversion mode.
// - Bits 3-0 at Downconv_mode_pair_cd give the pair CD down-conversion mode.
// - Setting bit 0 at B7h starts a trim load.
// - Bit 1 at 6Ah masks the reference pulse input.
// - Bits 6-4 at 6Fh hold the driver swing code.
// - Bits 5-0 at 71h hold the lane A de-emphasis code.
// - Bits 7-6 at 71h hold lane B de-emphasis bits 5 and 4.
// - Every register reads zero after reset.
// - Each access is 24 bits: a read flag, 15 address bits, then 8 data bits.
`timescale 1ns/1ps
`default_nettype none
module paged_config_register_bank (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sen_n,
	input wire logic sclk,
	input wire logic sdin,
	input wire logic sysref_in,
	output logic sdout,
	output logic sdout_oe_n,
	output logic sel_link_page_cd,
	output logic sel_link_page_ab,
	output logic sel_chan_page_d,
	output logic sel_chan_page_c,
	output logic sel_chan_page_b,
	output logic sel_chan_page_a,
	output logic sel_top_digital_page,
	output logic sel_analog_page,
	output logic trim_rate_sel,
	output logic trim_load_go,
	output logic [15:0] custom_word_one,
	output logic [15:0] custom_word_two,
	output logic [3:0] test_output_choice,
	output logic [3:0] test_out_en,
	output logic [15:0] test_word,
	output logic [3:0] test_active,
	output logic special_setting_bit_zero,
	output logic special_setting_bit_one,
	output logic [3:0] downconv_mode_ab,
	output logic [3:0] downconv_mode_cd,
	output logic ref_pulse_mask,
	output logic sysref_out,
	output logic [2:0] driver_swing_code,
	output logic [5:0] deemph_code_lane_a,
	output logic [1:0] deemph_code_lane_b_hi
);
	typedef struct packed {
		logic [6:0] sel_main;
		logic sel_analog;
		logic trim_rate;
		logic [15:0] cw1;
		logic [15:0] cw2;
		logic [3:0] choice;
		logic [3:0] en;
		logic special0;
		logic special1;
		logic [3:0] ddc_ab;
		logic [3:0] ddc_cd;
		logic trim_bit;
		logic trim_pulse;
		logic ref_mask;
		logic [2:0] swing;
		logic [5:0] deemph_a;
		logic [1:0] deemph_b_hi;
		logic [2:0] sysref_s;
		logic sysref_l;
		logic sysref_o;
		logic alt;
		logic [15:0] ramp;
		logic [15:0] pat_word;
		logic [3:0] pat_active;
	} bank_st_t;

	bank_st_t q;
	bank_st_t next_q;
	reg_access_if acc ();
	logic dig;
	logic ana;
	logic choice_ok;
	logic [3:0] act_c;
	logic [7:0] rdata_c;

	serial_reg_port u_port (
		.clk(clk),
		.rst_n(rst_n),
		.sen_n_pin(sen_n),
		.sclk_pin(sclk),
		.sdin_pin(sdin),
		.sdout(sdout),
		.sdout_oe_n(sdout_oe_n),
		.acc(acc.port)
	);

	assign dig = q.sel_main[cfg_bank_pkg::BIT_SEL_TOP];
	assign ana = q.sel_analog;

	// Reserved codes 5 and 9..15 leave the data path untouched
	always_comb begin
		case (q.choice)
			cfg_bank_pkg::PAT_ZEROS,
			cfg_bank_pkg::PAT_ONES,
			cfg_bank_pkg::PAT_TOGGLE,
			cfg_bank_pkg::PAT_RAMP,
			cfg_bank_pkg::PAT_CUSTOM1,
			cfg_bank_pkg::PAT_ALT,
			cfg_bank_pkg::PAT_DESKEW: begin
				choice_ok = 1'b1;
			end
			default: begin
				choice_ok = 1'b0;
			end
		endcase
	end

	for (genvar i = 0; i < 4; i++) begin : g_chan
		assign act_c[i] = q.en[i] && choice_ok;
	end

	// Read mux; pages share no offsets, so OR-ing hits is safe
	always_comb begin
		rdata_c = cfg_bank_pkg::RST_BYTE;
		case (acc.addr)
			cfg_bank_pkg::OFS_PAGE_MAIN: begin
				rdata_c = {1'b0, q.sel_main};
			end
			cfg_bank_pkg::OFS_PAGE_ANALOG: begin
				rdata_c = {7'h00, q.sel_analog};
			end
			default: begin
			end
		endcase
		if (dig) begin
			case (acc.addr)
				cfg_bank_pkg::OFS_TRIM_RATE: begin
					rdata_c = rdata_c | (8'(q.trim_rate) << cfg_bank_pkg::BIT_TRIM_RATE);
				end
				cfg_bank_pkg::OFS_CW1_LO: begin
					rdata_c = rdata_c | q.cw1[7:0];
				end
				cfg_bank_pkg::OFS_CW1_HI: begin
					rdata_c = rdata_c | q.cw1[15:8];
				end
				cfg_bank_pkg::OFS_CW2_LO: begin
					rdata_c = rdata_c | q.cw2[7:0];
				end
				cfg_bank_pkg::OFS_CW2_HI: begin
					rdata_c = rdata_c | q.cw2[15:8];
				end
				cfg_bank_pkg::OFS_TEST_CTRL: begin
					rdata_c = rdata_c | {q.choice, q.en};
				end
				cfg_bank_pkg::OFS_SPECIAL0: begin
					rdata_c = rdata_c | 8'(q.special0);
				end
				cfg_bank_pkg::OFS_SPECIAL1: begin
					rdata_c = rdata_c | 8'(q.special1);
				end
				cfg_bank_pkg::OFS_DDC_AB: begin
					rdata_c = rdata_c | {4'h0, q.ddc_ab};
				end
				cfg_bank_pkg::OFS_DDC_CD: begin
					rdata_c = rdata_c | {4'h0, q.ddc_cd};
				end
				cfg_bank_pkg::OFS_TRIM_GO: begin
					rdata_c = rdata_c | 8'(q.trim_bit);
				end
				default: begin
				end
			endcase
		end
		if (ana) begin
			case (acc.addr)
				cfg_bank_pkg::OFS_REF_MASK: begin
					rdata_c = rdata_c | (8'(q.ref_mask) << cfg_bank_pkg::BIT_REF_MASK);
				end
				cfg_bank_pkg::OFS_SWING: begin
					rdata_c = rdata_c | (8'(q.swing) << cfg_bank_pkg::LSB_SWING);
				end
				cfg_bank_pkg::OFS_DEEMPH: begin
					rdata_c = rdata_c | {q.deemph_b_hi, q.deemph_a};
				end
				default: begin
				end
			endcase
		end
	end

	assign acc.rdata = rdata_c;

	always_comb begin
		next_q = q;
		next_q.trim_pulse = 1'b0;
		if (acc.wr_stb) begin
			// Only defined bits are stored, so unused ones read zero
			case (acc.addr)
				cfg_bank_pkg::OFS_PAGE_MAIN: begin
					next_q.sel_main = acc.wdata[6:0];
				end
				cfg_bank_pkg::OFS_PAGE_ANALOG: begin
					next_q.sel_analog = acc.wdata[cfg_bank_pkg::BIT_SEL_ANALOG];
				end
				default: begin
				end
			endcase
			// Separate page checks; pages share no offsets, so one write lands in one page only
			if (dig) begin
				case (acc.addr)
					cfg_bank_pkg::OFS_TRIM_RATE: begin
						next_q.trim_rate = acc.wdata[cfg_bank_pkg::BIT_TRIM_RATE];
					end
					cfg_bank_pkg::OFS_CW1_LO: begin
						next_q.cw1[7:0] = acc.wdata;
					end
					cfg_bank_pkg::OFS_CW1_HI: begin
						next_q.cw1[15:8] = acc.wdata;
					end
					cfg_bank_pkg::OFS_CW2_LO: begin
						next_q.cw2[7:0] = acc.wdata;
					end
					cfg_bank_pkg::OFS_CW2_HI: begin
						next_q.cw2[15:8] = acc.wdata;
					end
					cfg_bank_pkg::OFS_TEST_CTRL: begin
						next_q.choice = acc.wdata[cfg_bank_pkg::LSB_CHOICE +: 4];
						next_q.en = acc.wdata[3:0];
					end
					cfg_bank_pkg::OFS_SPECIAL0: begin
						next_q.special0 = acc.wdata[cfg_bank_pkg::BIT_SPECIAL];
					end
					cfg_bank_pkg::OFS_SPECIAL1: begin
						next_q.special1 = acc.wdata[cfg_bank_pkg::BIT_SPECIAL];
					end
					cfg_bank_pkg::OFS_DDC_AB: begin
						next_q.ddc_ab = acc.wdata[3:0];
					end
					cfg_bank_pkg::OFS_DDC_CD: begin
						next_q.ddc_cd = acc.wdata[3:0];
					end
					cfg_bank_pkg::OFS_TRIM_GO: begin
						next_q.trim_bit = acc.wdata[cfg_bank_pkg::BIT_TRIM_GO];
						next_q.trim_pulse = acc.wdata[cfg_bank_pkg::BIT_TRIM_GO];
					end
					default: begin
					end
				endcase
			end
			if (ana) begin
				case (acc.addr)
					cfg_bank_pkg::OFS_REF_MASK: begin
						next_q.ref_mask = acc.wdata[cfg_bank_pkg::BIT_REF_MASK];
					end
					cfg_bank_pkg::OFS_SWING: begin
						next_q.swing = acc.wdata[cfg_bank_pkg::LSB_SWING +: 3];
					end
					cfg_bank_pkg::OFS_DEEMPH: begin
						next_q.deemph_a = acc.wdata[5:0];
						next_q.deemph_b_hi = acc.wdata[cfg_bank_pkg::LSB_DEEMPH_B +: 2];
					end
					default: begin
					end
				endcase
			end
		end
		// Reference pulse pin: three stages, level taken on agreement
		next_q.sysref_s = {q.sysref_s[1:0], sysref_in};
		if (q.sysref_s[1] == q.sysref_s[2]) begin
			next_q.sysref_l = q.sysref_s[2];
		end
		next_q.sysref_o = q.sysref_l && !q.ref_mask;
		// Pattern source advances every clock; toggle and ramp are free-running
		next_q.alt = !q.alt;
		next_q.ramp = q.ramp + cfg_bank_pkg::RAMP_STEP;
		case (q.choice)
			cfg_bank_pkg::PAT_ONES: begin
				next_q.pat_word = cfg_bank_pkg::ALL_ONES;
			end
			cfg_bank_pkg::PAT_TOGGLE: begin
				next_q.pat_word = q.alt ? cfg_bank_pkg::ALL_ONES : 16'h0000;
			end
			cfg_bank_pkg::PAT_RAMP: begin
				next_q.pat_word = q.ramp;
			end
			cfg_bank_pkg::PAT_CUSTOM1: begin
				next_q.pat_word = q.cw1;
			end
			cfg_bank_pkg::PAT_ALT: begin
				next_q.pat_word = q.alt ? q.cw2 : q.cw1;
			end
			cfg_bank_pkg::PAT_DESKEW: begin
				next_q.pat_word = cfg_bank_pkg::DESKEW_WORD;
			end
			default: begin
				next_q.pat_word = 16'h0000;
			end
		endcase
		next_q.pat_active = act_c;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign sel_link_page_cd = q.sel_main[cfg_bank_pkg::BIT_SEL_LINK_CD];
	assign sel_link_page_ab = q.sel_main[cfg_bank_pkg::BIT_SEL_LINK_AB];
	assign sel_chan_page_d = q.sel_main[cfg_bank_pkg::BIT_SEL_CHAN_A + 3];
	assign sel_chan_page_c = q.sel_main[cfg_bank_pkg::BIT_SEL_CHAN_A + 2];
	assign sel_chan_page_b = q.sel_main[cfg_bank_pkg::BIT_SEL_CHAN_A + 1];
	assign sel_chan_page_a = q.sel_main[cfg_bank_pkg::BIT_SEL_CHAN_A];
	assign sel_top_digital_page = q.sel_main[cfg_bank_pkg::BIT_SEL_TOP];
	assign sel_analog_page = q.sel_analog;
	assign trim_rate_sel = q.trim_rate;
	assign trim_load_go = q.trim_pulse;
	assign custom_word_one = q.cw1;
	assign custom_word_two = q.cw2;
	assign test_output_choice = q.choice;
	assign test_out_en = q.en;
	assign test_word = q.pat_word;
	assign test_active = q.pat_active;
	assign special_setting_bit_zero = q.special0;
	assign special_setting_bit_one = q.special1;
	assign downconv_mode_ab = q.ddc_ab;
	assign downconv_mode_cd = q.ddc_cd;
	assign ref_pulse_mask = q.ref_mask;
	assign sysref_out = q.sysref_o;
	assign driver_swing_code = q.swing;
	assign deemph_code_lane_a = q.deemph_a;
	assign deemph_code_lane_b_hi = q.deemph_b_hi;

	link_page_a: assert property (@(posedge clk) disable iff (!rst_n)
		acc.wr_stb && acc.addr == cfg_bank_pkg::OFS_PAGE_MAIN |=>
		sel_link_page_cd == $past(acc.wdata[6]) && sel_link_page_ab == $past(acc.wdata[5]))
		else $error("link page select not taken from write");
	chan_page_a: assert property (@(posedge clk) disable iff (!rst_n)
		acc.wr_stb && acc.addr == cfg_bank_pkg::OFS_PAGE_MAIN |=>
		{sel_chan_page_d, sel_chan_page_c, sel_chan_page_b, sel_chan_page_a} == $past(acc.wdata[4:1]))
		else $error("channel page selects not taken from write");
	top_digital_page_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		acc.wr_stb && acc.addr == cfg_bank_pkg::OFS_TRIM_RATE && !sel_top_digital_page |=>
		$stable(trim_rate_sel))
		else $error("top page written while deselected");
	analog_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		acc.wr_stb && acc.addr == cfg_bank_pkg::OFS_SWING && !sel_analog_page |=>
		$stable(driver_swing_code))
		else $error("analog page written while deselected");
	trim_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
		acc.wr_stb && acc.addr == cfg_bank_pkg::OFS_TRIM_RATE && sel_top_digital_page |=>
		trim_rate_sel == $past(acc.wdata[1]))
		else $error("trim rate bit not stored");
	custom_one_a: assert property (@(posedge clk) disable iff (!rst_n)
		test_output_choice == cfg_bank_pkg::PAT_CUSTOM1 |=> test_word == $past(custom_word_one))
		else $error("custom word one not on test output");
	alt_words_a: assert property (@(posedge clk) disable iff (!rst_n)
		test_output_choice == cfg_bank_pkg::PAT_ALT [*2] |=>
		(test_word == $past(custom_word_one) || test_word == $past(custom_word_two)) &&
		(test_word == $past(custom_word_two) || $past(test_word) == $past(custom_word_two, 2)))
		else $error("alternating custom words wrong");
	deskew_word_a: assert property (@(posedge clk) disable iff (!rst_n)
		test_output_choice == cfg_bank_pkg::PAT_DESKEW |=> test_word == 16'hAAAA)
		else $error("deskew word wrong");
	chan_active_a: assert property (@(posedge clk) disable iff (!rst_n)
		test_output_choice == cfg_bank_pkg::PAT_ONES |=> test_active == $past(test_out_en) && test_word == 16'hFFFF)
		else $error("per-channel pattern enable wrong");
	trim_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		acc.wr_stb && acc.addr == cfg_bank_pkg::OFS_TRIM_GO && sel_top_digital_page && acc.wdata[0] |=>
		trim_load_go ##1 !trim_load_go)
		else $error("trim load pulse missing or too long");
	ref_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
		ref_pulse_mask |=> !sysref_out)
		else $error("masked reference pulse passed");
	reset_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> q == '0 && !trim_load_go)
		else $error("register not zero after reset");
endmodule
`default_nettype wire

// ### tb/serial_host_model.sv
// Host controller model driving the serial register port
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
	input wire logic clk,
	output logic sen_n,
	output logic sclk,
	output logic sdin,
	input wire logic sdout,
	input wire logic sdout_oe_n
);
	// Six clocks a phase clears the input sync with margin
	localparam int HALF = 6;
	initial begin
		sen_n = 1'b1;
		sclk = 1'b0;
		sdin = 1'b0;
	end
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Short nbits cuts the word; keep leaves enable low for a burst
	task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] d, input int nbits, input bit keep,
		output logic [7:0] rd, output logic oe_ok);
		logic [23:0] w;
		w = {rw, a, d};
		rd = 8'h00;
		oe_ok = 1'b1;
		if (sen_n) begin
			sen_n = 1'b0;
			idle(HALF);
		end
		for (int i = 23; i >= 24 - nbits; i--) begin
			sclk = 1'b0;
			sdin = w[i];
			idle(HALF);
			sclk = 1'b1;
			if (i < 8) begin
				rd[i] = sdout;
				if (sdout_oe_n !== !rw)
					oe_ok = 1'b0;
			end
			idle(HALF);
		end
		if (!keep) begin
			sclk = 1'b0;
			idle(HALF);
			sen_n = 1'b1;
			// Released line shows the inverse, never a stale bit
			sdin = ~sdin;
			idle(HALF);
		end
	endtask
endmodule
`default_nettype wire

// ### tb/paged_config_register_bank_test.sv
// Self-checking bench for the paged configuration register bank
`timescale 1ns/1ps
`default_nettype none
module paged_config_register_bank_test;
	localparam int LIMIT = 50000;
	localparam logic [14:0] TA [12] = '{cfg_bank_pkg::OFS_TRIM_RATE, cfg_bank_pkg::OFS_REF_MASK, cfg_bank_pkg::OFS_SWING,
		cfg_bank_pkg::OFS_DEEMPH, cfg_bank_pkg::OFS_CW1_LO, cfg_bank_pkg::OFS_CW1_HI, cfg_bank_pkg::OFS_CW2_LO,
		cfg_bank_pkg::OFS_CW2_HI, cfg_bank_pkg::OFS_SPECIAL0, cfg_bank_pkg::OFS_SPECIAL1, cfg_bank_pkg::OFS_DDC_AB,
		cfg_bank_pkg::OFS_DDC_CD};
	// Unused bits always written as zero, so read-back equals the write
	localparam logic [7:0] TW [12] = '{8'h02, 8'h02, 8'h70, 8'hC7, 8'h34, 8'h12, 8'hCD, 8'hAB, 8'h01, 8'h01, 8'h03, 8'h08};
	localparam logic [3:0] MODES [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sysref_in = 1'b0;
	logic sen_n, sclk, sdin, sdout, sdout_oe_n, sel_link_page_cd, sel_link_page_ab, sel_chan_page_d, sel_chan_page_c;
	logic sel_chan_page_b, sel_chan_page_a, sel_top_digital_page, sel_analog_page, trim_rate_sel, trim_load_go;
	logic special_setting_bit_zero, special_setting_bit_one, ref_pulse_mask, sysref_out, oe_ok, valid;
	logic [15:0] custom_word_one, custom_word_two, test_word, w0, w1;
	logic [3:0] test_output_choice, test_out_en, test_active, downconv_mode_ab, downconv_mode_cd, en;
	logic [2:0] driver_swing_code;
	logic [5:0] deemph_code_lane_a;
	logic [1:0] deemph_code_lane_b_hi;
	logic [7:0] rd;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int pulses = 0;
	paged_config_register_bank i_paged_config_register_bank (.clk, .rst_n, .sen_n, .sclk, .sdin, .sysref_in, .sdout,
		.sdout_oe_n, .sel_link_page_cd, .sel_link_page_ab, .sel_chan_page_d, .sel_chan_page_c, .sel_chan_page_b,
		.sel_chan_page_a, .sel_top_digital_page, .sel_analog_page, .trim_rate_sel, .trim_load_go, .custom_word_one,
		.custom_word_two, .test_output_choice, .test_out_en, .test_word, .test_active, .special_setting_bit_zero,
		.special_setting_bit_one, .downconv_mode_ab, .downconv_mode_cd, .ref_pulse_mask, .sysref_out,
		.driver_swing_code, .deemph_code_lane_a, .deemph_code_lane_b_hi);
	serial_host_model i_serial_host_model (.clk, .sen_n, .sclk, .sdin, .sdout, .sdout_oe_n);
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			num_errors++;
			wrap_up();
		end
	end
	always @(negedge clk)
		if (trim_load_go === 1'b1)
			pulses++;
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		i_serial_host_model.xfer(1'b0, a, d, 24, 1'b0, rd, oe_ok);
		check_val({15'h0000, oe_ok}, 16'h0001);
	endtask
	task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
		i_serial_host_model.xfer(1'b1, a, 8'h00, 24, 1'b0, rd, oe_ok);
		check_val({7'h00, oe_ok, rd}, {8'h01, e});
	endtask
	task automatic chk_reset();
		check_val({sdout_oe_n, sel_link_page_cd, sel_link_page_ab, sel_chan_page_d, sel_chan_page_c, sel_chan_page_b,
			sel_chan_page_a, sel_top_digital_page, sel_analog_page, trim_rate_sel, ref_pulse_mask,
			special_setting_bit_zero, special_setting_bit_one, driver_swing_code}, 16'h8000);
		check_val({downconv_mode_ab, downconv_mode_cd, deemph_code_lane_a, deemph_code_lane_b_hi}, 16'h0000);
		check_val(custom_word_one | custom_word_two | test_word, 16'h0000);
		check_val({test_output_choice, test_out_en, test_active, 2'h0, sysref_out, trim_load_go}, 16'h0000);
	endtask
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		chk_reset();
		// Pages still closed, so both writes must be dropped
		wr(cfg_bank_pkg::OFS_TRIM_RATE, 8'h02);
		wr(cfg_bank_pkg::OFS_REF_MASK, 8'h02);
		check_val({15'h0000, trim_rate_sel}, 16'h0000);
		check_val({15'h0000, ref_pulse_mask}, 16'h0000);
		wr(cfg_bank_pkg::OFS_PAGE_MAIN, 8'h7F);
		check_val({9'h000, sel_link_page_cd, sel_link_page_ab, sel_chan_page_d, sel_chan_page_c, sel_chan_page_b,
			sel_chan_page_a, sel_top_digital_page}, 16'h007F);
		rd_chk(cfg_bank_pkg::OFS_PAGE_MAIN, 8'h7F);
		wr(cfg_bank_pkg::OFS_PAGE_ANALOG, 8'h01);
		check_val({15'h0000, sel_analog_page}, 16'h0001);
		rd_chk(cfg_bank_pkg::OFS_PAGE_ANALOG, 8'h01);
		for (int k = 0; k < 12; k++)
			rd_chk(TA[k], 8'h00);
		rd_chk(cfg_bank_pkg::OFS_TEST_CTRL, 8'h00);
		rd_chk(cfg_bank_pkg::OFS_TRIM_GO, 8'h00);
		rd_chk(15'h0065, 8'h00);
		i_serial_host_model.xfer(1'b0, cfg_bank_pkg::OFS_TRIM_RATE, 8'h02, 20, 1'b0, rd, oe_ok);
		check_val({15'h0000, trim_rate_sel}, 16'h0000);
		// One enable low for the whole burst of twelve words
		for (int k = 0; k < 12; k++)
			i_serial_host_model.xfer(1'b0, TA[k], TW[k], 24, k < 11, rd, oe_ok);
		check_val({15'h0000, trim_rate_sel}, 16'h0001);
		for (int k = 0; k < 12; k++)
			rd_chk(TA[k], TW[k]);
		check_val(custom_word_one, 16'h1234);
		check_val(custom_word_two, 16'hABCD);
		check_val({3'h0, special_setting_bit_zero, special_setting_bit_one, driver_swing_code, deemph_code_lane_a,
			deemph_code_lane_b_hi}, 16'h1F1F);
		check_val({8'h00, downconv_mode_ab, downconv_mode_cd}, 16'h0038);
		check_val({15'h0000, ref_pulse_mask}, 16'h0001);
		wr(cfg_bank_pkg::OFS_TRIM_RATE, 8'h00);
		check_val({15'h0000, trim_rate_sel}, 16'h0000);
		for (int k = 0; k < 8; k++) begin
			wr(cfg_bank_pkg::OFS_DDC_AB, {4'h0, MODES[k]});
			wr(cfg_bank_pkg::OFS_DDC_CD, {4'h0, MODES[7 - k]});
			check_val({8'h00, downconv_mode_ab, downconv_mode_cd}, {8'h00, MODES[k], MODES[7 - k]});
		end
		// A repeated one must start a second load
		wr(cfg_bank_pkg::OFS_TRIM_GO, 8'h01);
		check_val(pulses[15:0], 16'h0001);
		wr(cfg_bank_pkg::OFS_TRIM_GO, 8'h01);
		check_val(pulses[15:0], 16'h0002);
		rd_chk(cfg_bank_pkg::OFS_TRIM_GO, 8'h01);
		wr(cfg_bank_pkg::OFS_TRIM_GO, 8'h00);
		check_val(pulses[15:0], 16'h0002);
		wr(cfg_bank_pkg::OFS_REF_MASK, 8'h00);
		sysref_in = 1'b1;
		repeat (8) @(negedge clk);
		check_val({15'h0000, sysref_out}, 16'h0001);
		wr(cfg_bank_pkg::OFS_REF_MASK, 8'h02);
		check_val({15'h0000, sysref_out}, 16'h0000);
		sysref_in = 1'b0;
		for (int c = 0; c < 9; c++) begin
			en = c[0] ? 4'h5 : 4'hA;
			wr(cfg_bank_pkg::OFS_TEST_CTRL, {c[3:0], en});
			@(negedge clk);
			w0 = test_word;
			@(negedge clk);
			w1 = test_word;
			valid = !(c == 0 || c == 5);
			check_val({8'h00, test_output_choice, test_out_en}, {8'h00, c[3:0], en});
			check_val({12'h000, test_active}, {12'h000, valid ? en : 4'h0});
			case (c)
				0, 1, 5: check_val(w0, 16'h0000);
				2: check_val(w0, 16'hFFFF);
				3: check_val(w0 ^ w1, 16'hFFFF);
				4: check_val(w1 - w0, 16'h0001);
				6: check_val(w0, 16'h1234);
				7: check_val({15'h0000, (w0 === 16'h1234 && w1 === 16'hABCD) || (w0 === 16'hABCD && w1 === 16'h1234)},
					16'h0001);
				default: check_val(w0, 16'hAAAA);
			endcase
		end
		// Second reset in mid-run must clear every stored setting
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		chk_reset();
		wrap_up();
	end
endmodule
`default_nettype wire
